// ---- common/secreg_regs.vh ----
`ifndef SECREG_REGS_VH
`define SECREG_REGS_VH

// Functional notes
// - Command 35h plus three address bytes selects a 64-Kbyte sector lock query.
// - After the query address, output repeats FFh if sector locked, else 00h.
// - Above the low read clock limit the first query byte is invalid.
// - Chip select high ends either read at once and floats the output.
// - Security memory is 128 bytes: 0-63 user, 64-127 fixed factory data.
// - User area needs no erase; programmed once as a whole, later attempts refused.
// - Program start offset uses address bits 5:0 only; bits 23:6 are ignored.
// - Data bytes fill the buffer from the offset, wrapping past 63 to 0.
// - More than 64 data bytes leaves only the last 64 in the buffer.
// - Chip select rise starts self-timed programming; unsent bytes stay FFh.
// - Suspend requests are rejected while the user area is programming.
// - Program needs full address, one full data byte, byte-aligned release.
// - Every security program abort clears the write enable latch.
// - Busy reads high while programming; latch clears before completion.
// - Program command overwrites the shared page buffer contents.
// - Read is 77h, three address bytes, two dummy bytes, then data.
// - Security read advances sequentially, wrapping 7Fh to 00h without delay.
// - Status command 05h: bit 0 busy, bit 1 write enable latch; the code shows the latch only in every other status byte.

// Command codes
`define CMD_LOCK_QUERY 8'h35
`define CMD_SEC_PROGRAM 8'h9b
`define CMD_SEC_READ 8'h77
`define CMD_STATUS_READ 8'h05

// Data values
`define LOCK_SET_BYTE 8'hff
`define LOCK_CLR_BYTE 8'h00
`define ERASED_BYTE 8'hff

// Status byte fields
`define STAT_BUSY_BIT 0
`define STAT_WEL_BIT 1

// Header byte positions (zero based, command is byte 0)
`define LAST_ADDR_BYTE 3'd3
`define LAST_DUMMY_BYTE 3'd5
`define FIRST_DATA_CNT 3'd5
`define BYTE_CNT_MAX 3'd7

// Sector number within the address
`define SECTOR_MSB 21
`define SECTOR_LSB 16

// Timing
`define CLK_PERIOD_NS 10
`define SEC_PROG_TIME_US 1000

// Output prefetch buffer
`define OUT_FIFO_DEPTH 4
`define OUT_FIFO_AW 2

`endif

// ---- rtl/byte_fifo.v ----
`default_nettype none

module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire flush_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;
    wire [AW:0] depth_w;

    ////////////////////////////////////////////////////////////////////////
    // Handshake terms
    assign depth_w = DEPTH[AW:0];
    assign in_ready_o = (count_reg != depth_w);
    assign out_valid_o = (count_reg != {(AW+1){1'b0}});
    assign out_data_o = store[rd_ptr_reg];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // Storage has no reset; only pointers matter
    always @(posedge clk_i) begin
        if (push) begin
            store[wr_ptr_reg] <= in_data_i;
        end
    end

    // Pointers; flush wins so stale bytes never leak into a new frame
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else if (flush_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ---- rtl/secreg_access.v ----
`include "secreg_regs.vh"
`default_nettype none

module secreg_access #(
    parameter PROG_TIME_US = `SEC_PROG_TIME_US,
    // Factory data; arbitrary neutral value
    parameter [511:0] SERIAL_NUMBER = {8{64'h0f1e2d3c4b5a6978}}
) (
    input wire CLK_I,
    input wire RST_B_I,
    input wire CS_B_I,
    input wire SCK_I,
    input wire SI_I,
    input wire WEL_I,
    input wire SUSPEND_REQ_I,
    input wire [63:0] LOCK_FLAGS_I,
    output reg SO_O,
    output reg SO_OE_O,
    output reg BUSY_O,
    output reg WEL_CLR_O,
    output reg SUSPEND_REJECT_O
);

    // Which source feeds the output prefetch
    localparam [1:0] MODE_NONE = 2'd0;
    localparam [1:0] MODE_LOCK = 2'd1;
    localparam [1:0] MODE_STATUS = 2'd2;
    localparam [1:0] MODE_SECREAD = 2'd3;

    // Longest time, so round down
    localparam integer PROG_CYCLES = (PROG_TIME_US * 1000) / `CLK_PERIOD_NS;
    localparam integer PROG_LAST_INT = PROG_CYCLES - 1;
    // Counter is 24 bits wide; the default time needs only 17 of them
    localparam [23:0] PROG_LAST = PROG_LAST_INT[23:0];
    localparam [23:0] COPY_END = 24'h000040;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    // Stage one may go metastable; only stage two is read
    reg cs_b_s1_reg;
    reg cs_b_s2_reg;
    reg cs_b_prev_reg;
    reg sck_s1_reg;
    reg sck_s2_reg;
    reg sck_prev_reg;
    reg si_s1_reg;
    reg si_s2_reg;

    // Two flops per pin; only the second stage feeds logic
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cs_b_s1_reg <= 1'b1;
            cs_b_s2_reg <= 1'b1;
            cs_b_prev_reg <= 1'b1;
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_prev_reg <= 1'b0;
            si_s1_reg <= 1'b0;
            si_s2_reg <= 1'b0;
        end else begin
            cs_b_s1_reg <= CS_B_I;
            cs_b_s2_reg <= cs_b_s1_reg;
            cs_b_prev_reg <= cs_b_s2_reg;
            sck_s1_reg <= SCK_I;
            sck_s2_reg <= sck_s1_reg;
            sck_prev_reg <= sck_s2_reg;
            si_s1_reg <= SI_I;
            si_s2_reg <= si_s1_reg;
        end
    end

    // Edges only count inside a frame; mode 3 idle-high clock is harmless
    // A cut frame still ends: chip select alone resets the sequencer
    wire frame_on = ~cs_b_s2_reg;
    wire sck_rise = frame_on & sck_s2_reg & ~sck_prev_reg;
    wire sck_fall = frame_on & ~sck_s2_reg & sck_prev_reg;
    wire frame_end = cs_b_s2_reg & ~cs_b_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // Input byte assembly and command decode

    // Bit and byte counters restart whenever chip select is high
    reg [6:0] in_shift_reg;
    reg [2:0] bit_idx_reg;
    reg [2:0] byte_cnt_reg;
    reg [7:0] cmd_reg;
    reg [23:0] addr_reg;
    reg [1:0] out_mode_reg;
    reg [6:0] rd_addr_reg;
    reg stat_sel_reg;

    wire [7:0] in_byte = {in_shift_reg, si_s2_reg};
    wire byte_done = sck_rise & (bit_idx_reg == 3'd7);
    wire is_prog = (cmd_reg == `CMD_SEC_PROGRAM);
    wire data_byte = byte_done & is_prog & (byte_cnt_reg > `LAST_ADDR_BYTE);
    // While busy only the status read is decoded
    wire cmd_allowed = ~BUSY_O | (in_byte == `CMD_STATUS_READ);

    // Shared prefetch push and serializer pop
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    reg [7:0] fetch_byte;
    reg [2:0] out_left_reg;
    reg [6:0] out_sh_reg;
    wire fetch_push = (out_mode_reg != MODE_NONE) & fifo_in_ready;
    wire out_pop = sck_fall & (out_mode_reg != MODE_NONE) &
        (out_left_reg == 3'd0) & fifo_out_valid;

    // Frame sequencer; chip select high clears counters, command and mode at once
    // Byte count saturates at seven so long data phases stay in range
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            in_shift_reg <= 7'h00;
            bit_idx_reg <= 3'd0;
            byte_cnt_reg <= 3'd0;
            cmd_reg <= 8'h00;
            addr_reg <= 24'h000000;
            out_mode_reg <= MODE_NONE;
            rd_addr_reg <= 7'h00;
            stat_sel_reg <= 1'b0;
        end else if (!frame_on) begin
            // Outside a frame only counters, status select, command and mode are cleared
            bit_idx_reg <= 3'd0;
            byte_cnt_reg <= 3'd0;
            cmd_reg <= 8'h00;
            out_mode_reg <= MODE_NONE;
            stat_sel_reg <= 1'b0;
        end else begin
            if (sck_rise) begin
                in_shift_reg <= in_byte[6:0];
                bit_idx_reg <= bit_idx_reg + 3'd1;
            end
            if (byte_done) begin
                if (byte_cnt_reg != `BYTE_CNT_MAX) begin
                    byte_cnt_reg <= byte_cnt_reg + 3'd1;
                end
                if (byte_cnt_reg == 3'd0) begin
                    // Refused commands decode as none and leave no trace
                    cmd_reg <= cmd_allowed ? in_byte : 8'h00;
                    if (in_byte == `CMD_STATUS_READ) begin
                        out_mode_reg <= MODE_STATUS;
                    end
                end else if (byte_cnt_reg <= `LAST_ADDR_BYTE) begin
                    addr_reg <= {addr_reg[15:0], in_byte};
                end
                // Query output starts right after the third address byte
                if (byte_cnt_reg == `LAST_ADDR_BYTE && cmd_reg == `CMD_LOCK_QUERY) begin
                    out_mode_reg <= MODE_LOCK;
                end
                // Read output starts after the two dummy bytes
                if (byte_cnt_reg == `LAST_DUMMY_BYTE && cmd_reg == `CMD_SEC_READ) begin
                    out_mode_reg <= MODE_SECREAD;
                    rd_addr_reg <= addr_reg[6:0];
                end
            end
            // Each pushed byte advances the source
            if (fetch_push) begin
                rd_addr_reg <= rd_addr_reg + 7'd1;
                stat_sel_reg <= ~stat_sel_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Security memory

    // Cells start erased; keeping them over power loss is not modelled
    reg [7:0] user_mem [0:63];
    reg [7:0] page_buf [0:63];
    reg [63:0] otp_mask_reg;
    reg [63:0] buf_mask_reg;
    reg [5:0] prog_wptr_reg;
    reg otp_used_reg;
    reg [23:0] prog_cnt_reg;
    wire [5:0] copy_idx = prog_cnt_reg[5:0];
    wire copy_on = BUSY_O & (prog_cnt_reg < COPY_END);
    wire [8:0] sn_base = {rd_addr_reg[5:0], 3'b000};

    // Abort causes kept apart so each one can be traced on its own
    wire hdr_complete = (byte_cnt_reg >= `FIRST_DATA_CNT);
    wire byte_aligned = (bit_idx_reg == 3'd0);
    wire first_program = ~otp_used_reg;
    wire prog_accept = hdr_complete & byte_aligned & first_program & WEL_I;

    // Source of the next output byte
    // Status is sampled at push time, so it may trail by the prefetch depth
    always @* begin
        fetch_byte = 8'h00;
        case (out_mode_reg)
            MODE_LOCK: begin
                fetch_byte = LOCK_FLAGS_I[addr_reg[`SECTOR_MSB:`SECTOR_LSB]] ?
                    `LOCK_SET_BYTE : `LOCK_CLR_BYTE;
            end
            MODE_STATUS: begin
                fetch_byte = 8'h00;
                fetch_byte[`STAT_BUSY_BIT] = BUSY_O;
                fetch_byte[`STAT_WEL_BIT] = stat_sel_reg ? 1'b0 : WEL_I;
            end
            MODE_SECREAD: begin
                // Upper half is fixed factory data
                if (rd_addr_reg[6]) begin
                    fetch_byte = SERIAL_NUMBER[sn_base +: 8];
                end else if (otp_mask_reg[rd_addr_reg[5:0]]) begin
                    fetch_byte = user_mem[rd_addr_reg[5:0]];
                end else begin
                    fetch_byte = `ERASED_BYTE;
                end
            end
            default: begin
                fetch_byte = 8'h00;
            end
        endcase
    end

    // Page buffer fill; a newer byte at the same slot replaces the older one
    // Only 64 of the shared 256 buffer bytes are used by this command
    always @(posedge CLK_I) begin
        if (data_byte) begin
            page_buf[prog_wptr_reg] <= in_byte;
        end
    end

    // User area cells only; the upper half of the memory is never written
    // Copy runs one cell per cycle from the buffer
    always @(posedge CLK_I) begin
        if (copy_on && buf_mask_reg[copy_idx]) begin
            user_mem[copy_idx] <= page_buf[copy_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program control

    // Buffer bookkeeping, acceptance check and the self-timed cycle
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            otp_mask_reg <= 64'h0000000000000000;
            buf_mask_reg <= 64'h0000000000000000;
            prog_wptr_reg <= 6'd0;
            otp_used_reg <= 1'b0;
            prog_cnt_reg <= 24'h000000;
            BUSY_O <= 1'b0;
            WEL_CLR_O <= 1'b0;
        end else begin
            WEL_CLR_O <= 1'b0;
            // New program command discards old buffer contents
            if (byte_done && byte_cnt_reg == 3'd0 && cmd_allowed &&
                    in_byte == `CMD_SEC_PROGRAM) begin
                buf_mask_reg <= 64'h0000000000000000;
            end
            if (byte_done && byte_cnt_reg == `LAST_ADDR_BYTE && is_prog) begin
                prog_wptr_reg <= in_byte[5:0];
            end
            if (data_byte) begin
                buf_mask_reg[prog_wptr_reg] <= 1'b1;
                prog_wptr_reg <= prog_wptr_reg + 6'd1;
            end
            // Accept only complete, aligned, first-time programs
            if (frame_end && is_prog) begin
                WEL_CLR_O <= 1'b1;
                if (prog_accept) begin
                    BUSY_O <= 1'b1;
                    otp_used_reg <= 1'b1;
                    prog_cnt_reg <= 24'h000000;
                end
            end
            // Self-timed phase: the first 64 cycles copy, the rest only wait
            if (BUSY_O) begin
                if (copy_on && buf_mask_reg[copy_idx]) begin
                    otp_mask_reg[copy_idx] <= 1'b1;
                end
                prog_cnt_reg <= prog_cnt_reg + 24'h000001;
                if (prog_cnt_reg >= PROG_LAST) begin
                    BUSY_O <= 1'b0;
                end
            end
        end
    end

    // Programming cannot be suspended
    // Refusal is only reported; the program counter keeps running
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            SUSPEND_REJECT_O <= 1'b0;
        end else begin
            SUSPEND_REJECT_O <= SUSPEND_REQ_I & BUSY_O;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output prefetch and serializer

    // Prefetch hides memory latency behind the half clock before each byte
    // Flush on deselect so every frame starts with an empty queue
    byte_fifo #(
        .WIDTH(8),
        .DEPTH(`OUT_FIFO_DEPTH),
        .AW(`OUT_FIFO_AW)
    ) u_out_fifo (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .flush_i(cs_b_s2_reg),
        .in_valid_i(out_mode_reg != MODE_NONE),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fetch_byte),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(out_pop),
        .out_data_o(fifo_out_data)
    );

    // Shift out MSB first on falling edges; status may lag by prefetch depth
    // A partial byte just stops when chip select rises
    // Output enable follows the first falling edge of the phase
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            SO_O <= 1'b0;
            SO_OE_O <= 1'b0;
            out_left_reg <= 3'd0;
            out_sh_reg <= 7'h00;
        end else if (!frame_on) begin
            SO_OE_O <= 1'b0;
            out_left_reg <= 3'd0;
        end else if (sck_fall && out_mode_reg != MODE_NONE) begin
            SO_OE_O <= 1'b1;
            // Load a fresh byte only once the last one has gone out
            if (out_left_reg == 3'd0) begin
                if (fifo_out_valid) begin
                    SO_O <= fifo_out_data[7];
                    out_sh_reg <= fifo_out_data[6:0];
                    out_left_reg <= 3'd7;
                end
            end else begin
                SO_O <= out_sh_reg[6];
                out_sh_reg <= {out_sh_reg[5:0], 1'b0};
                out_left_reg <= out_left_reg - 3'd1;
            end
        end
    end

endmodule

`default_nettype wire

// ---- testbench/secreg_access_props.sv ----
`default_nettype none
module secreg_access_props #(
    parameter PROG_TIME_US = 1
) (
    input wire CLK_I,
    input wire RST_B_I,
    input wire CS_B_I,
    input wire SCK_I,
    input wire SI_I,
    input wire WEL_I,
    input wire SUSPEND_REQ_I,
    input wire [63:0] LOCK_FLAGS_I,
    input wire SO_O,
    input wire SO_OE_O,
    input wire BUSY_O,
    input wire WEL_CLR_O,
    input wire SUSPEND_REJECT_O
);
    localparam int PROG_CYCLES = PROG_TIME_US * 100;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    int busy_cnt_reg;
    ////////////////////////////////////////////////////////////
    // Busy length; restarts at zero so a stuck flag shows up
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I)
            busy_cnt_reg <= 0;
        else if (BUSY_O)
            busy_cnt_reg <= busy_cnt_reg + 1;
        else
            busy_cnt_reg <= 0;
    end
    sequence cs_idle_s;
        CS_B_I [*6];
    endsequence
    sequence prog_start_s;
        $rose(BUSY_O);
    endsequence
    ////////////////////////////////////////////////////////////
    so_float_idle_a: assert property (cs_idle_s |-> !SO_OE_O)
        else $error("serial output driven while deselected");
    prog_clear_wel_a: assert property (prog_start_s |-> WEL_CLR_O)
        else $error("latch not cleared at program start");
    prog_after_cs_a: assert property (prog_start_s |-> $past(CS_B_I, 2) && CS_B_I)
        else $error("program began while selected");
    prog_length_a: assert property ($fell(BUSY_O) |->
        busy_cnt_reg >= PROG_CYCLES - 1 && busy_cnt_reg <= PROG_CYCLES + 1)
        else $error("program time wrong");
    clr_pulse_a: assert property (WEL_CLR_O |=> !WEL_CLR_O)
        else $error("latch clear longer than one cycle");
    suspend_refuse_a: assert property (SUSPEND_REQ_I && BUSY_O |=> SUSPEND_REJECT_O)
        else $error("suspend not refused");
    reject_cause_a: assert property (SUSPEND_REJECT_O |-> $past(SUSPEND_REQ_I) && $past(BUSY_O))
        else $error("refusal without request");
    oe_on_fall_a: assert property ($rose(SO_OE_O) |-> !$past(SCK_I, 3) && !$past(CS_B_I, 3))
        else $error("output enabled off a clock fall");
    so_on_fall_a: assert property (SO_OE_O && $changed(SO_O) |-> !$past(SCK_I, 3))
        else $error("output changed off a clock fall");
endmodule

bind secreg_access secreg_access_props #(.PROG_TIME_US(PROG_TIME_US)) u_props (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .CS_B_I(CS_B_I), .SCK_I(SCK_I), .SI_I(SI_I),
    .WEL_I(WEL_I), .SUSPEND_REQ_I(SUSPEND_REQ_I), .LOCK_FLAGS_I(LOCK_FLAGS_I),
    .SO_O(SO_O), .SO_OE_O(SO_OE_O), .BUSY_O(BUSY_O), .WEL_CLR_O(WEL_CLR_O),
    .SUSPEND_REJECT_O(SUSPEND_REJECT_O));
`default_nettype wire

// ---- testbench/spi_host_model.sv ----
`default_nettype none
module spi_host_model (
    output logic cs_b_o,
    output logic sck_o,
    output logic si_o,
    input wire logic so_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle: deselected, clock resting low between frames
    initial begin
        cs_b_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end
    // Link edges sit 1 ns off the system clock grid, never on a sampling edge
    task automatic open_f();
        cs_b_o = 1'b0;
        #1;
    endtask
    // nb bits MSB first, 125 ns period; SO sampled at each rise
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            si_o = tx[i];
            #62.5 sck_o = 1'b1;
            rx[i] = so_i;
            #62.5 sck_o = 1'b0;
        end
    endtask
    // Released line flips so a stale bit never reads as valid
    task automatic close_f();
        #62.5 cs_b_o = 1'b1;
        si_o = ~si_o;
    endtask
endmodule
`default_nettype wire

// ---- testbench/spi_flash_security_register_access_bench.sv ----
`include "secreg_regs.vh"
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin n_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module spi_flash_security_register_access_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [511:0] SN = {16{32'h13579bdf}};
    logic clk = 1'b0;
    logic rst_b, cs_b, sck, si, write_enable_latch, susp, so, so_oe, busy, wel_clr, susp_rej;
    logic [63:0] lock_flags;
    logic [7:0] rx;
    logic [7:0] mem [0:63];
    int n_errors = 0;
    int checked = 0;
    int n_clr = 0;
    wire so_line;
    // Undriven output reads as high impedance, never as data
    assign so_line = so_oe ? so : 1'bz;
    always #5 clk = ~clk;
    // Device-side latch: cleared by the block's pulse
    always @(negedge clk) begin
        if (wel_clr === 1'b1) begin
            write_enable_latch <= 1'b0;
            n_clr <= n_clr + 1;
        end
    end
    secreg_access #(.PROG_TIME_US(20), .SERIAL_NUMBER(SN)) u_dut (
        .CLK_I(clk), .RST_B_I(rst_b), .CS_B_I(cs_b), .SCK_I(sck), .SI_I(si),
        .WEL_I(write_enable_latch), .SUSPEND_REQ_I(susp), .LOCK_FLAGS_I(lock_flags), .SO_O(so),
        .SO_OE_O(so_oe), .BUSY_O(busy), .WEL_CLR_O(wel_clr), .SUSPEND_REJECT_O(susp_rej));
    spi_host_model u_host (.cs_b_o(cs_b), .sck_o(sck), .si_o(si), .so_i(so_line));
    ////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic hdr(input logic [7:0] c, input logic [23:0] a);
        u_host.open_f();
        u_host.xfer(c, 8, rx);
        for (int i = 2; i >= 0; i--)
            u_host.xfer(a[i*8 +: 8], 8, rx);
    endtask
    // Deselect and keep the gap well above the minimum
    task automatic fin();
        u_host.close_f();
        repeat (10) @(negedge clk);
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            n_errors++;
            $display("[FAIL] busy wait timed out");
            close_out();
        end
    endtask
    function automatic logic [7:0] exp_at(input logic [6:0] a);
        return a[6] ? SN[a[5:0]*8 +: 8] : mem[a[5:0]];
    endfunction
    task automatic rd_chk(input logic [23:0] a, input int n);
        hdr(`CMD_SEC_READ, a);
        u_host.xfer(8'h00, 8, rx);
        u_host.xfer(8'h00, 8, rx);
        for (int i = 0; i < n; i++) begin
            u_host.xfer(8'h00, 8, rx);
            `CHK("security byte", exp_at(a[6:0] + i[6:0]), rx)
        end
        fin();
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_lock();
        lock_flags = 64'h0;
        lock_flags[5] = 1'b1;
        for (int s = 5; s <= 6; s++) begin
            hdr(`CMD_LOCK_QUERY, {2'b00, s[5:0], 16'habcd});
            u_host.xfer(8'h00, 8, rx);
            u_host.xfer(8'h00, 8, rx);
            `CHK("lock byte", (s == 5) ? `LOCK_SET_BYTE : `LOCK_CLR_BYTE, rx)
            u_host.xfer(8'h00, 3, rx);
            fin();
            `CHK("output enable", 1'b0, so_oe)
        end
        $display("test lock query done");
    endtask
    task automatic t_read();
        rd_chk(24'h00003e, 4);
        rd_chk(24'h00007e, 4);
        $display("test erased read done");
    endtask
    // Short address, then a partial data byte: both must abort
    task automatic t_abort();
        int c0;
        c0 = n_clr;
        write_enable_latch = 1'b1;
        u_host.open_f();
        u_host.xfer(`CMD_STATUS_READ, 8, rx);
        repeat (3) u_host.xfer(8'h00, 8, rx);
        `CHK("status latch", 8'h02, rx)
        fin();
        u_host.open_f();
        u_host.xfer(`CMD_SEC_PROGRAM, 8, rx);
        u_host.xfer(8'h00, 8, rx);
        u_host.xfer(8'h00, 8, rx);
        fin();
        `CHK("busy short address", 1'b0, busy)
        write_enable_latch = 1'b1;
        hdr(`CMD_SEC_PROGRAM, 24'h000000);
        u_host.xfer(8'h5a, 8, rx);
        u_host.xfer(8'h5a, 3, rx);
        fin();
        `CHK("busy partial byte", 1'b0, busy)
        `CHK("latch clears", c0 + 2, n_clr)
        rd_chk(24'h000000, 2);
        $display("test program abort done");
    endtask
    task automatic t_program();
        int c0;
        c0 = n_clr;
        write_enable_latch = 1'b1;
        hdr(`CMD_SEC_PROGRAM, 24'hffffbe);
        for (int k = 0; k < 66; k++) begin
            u_host.xfer(k[7:0] + 8'h20, 8, rx);
            mem[(k + 62) % 64] = k[7:0] + 8'h20;
        end
        u_host.close_f();
        wait_busy(1'b1, 20);
        @(negedge clk);
        `CHK("latch clear at start", c0 + 1, n_clr)
        susp = 1'b1;
        @(negedge clk);
        susp = 1'b0;
        `CHK("suspend refused", 1'b1, susp_rej)
        u_host.open_f();
        u_host.xfer(`CMD_STATUS_READ, 8, rx);
        repeat (4) u_host.xfer(8'h00, 8, rx);
        `CHK("status busy", 8'h01, rx)
        fin();
        wait_busy(1'b0, 3000);
        rd_chk(24'h000000, 64);
        write_enable_latch = 1'b1;
        hdr(`CMD_SEC_PROGRAM, 24'h000000);
        u_host.xfer(8'h55, 8, rx);
        fin();
        `CHK("second program", 1'b0, busy)
        `CHK("refusal clears latch", c0 + 2, n_clr)
        rd_chk(24'h000000, 1);
        $display("test program done");
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        write_enable_latch = 1'b0;
        susp = 1'b0;
        lock_flags = 64'h0;
        for (int i = 0; i < 64; i++)
            mem[i] = `ERASED_BYTE;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        repeat (5) @(negedge clk);
        t_lock();
        t_read();
        t_abort();
        t_program();
        close_out();
    end
endmodule
`default_nettype wire
